// File: rtl/mode_decode.sv
// Opcode to operand mode decoder
`timescale 1ns/10ps
`include "oag_defs.svh"
module mode_decode
  import oag_pkg::*;
(
  input  wire logic [7:0]    opcode,
  output operand_mode_e      mode,
  output logic [3:0]         operation,
  output logic [2:0]         length
);
  // Upper nibble picks the mode, lower nibble the operation
  always_comb begin
    operation = opcode[3:0];
    case (opcode[7:4])
      `MODE_FULL_ADDR: begin
        mode   = full_address_mode;
        length = `LEN_FULL_ADDR;
      end
      `MODE_PTR_NO_OFS, `MODE_PTR_NO_OFS_RMW: begin
        mode   = pointer_no_offset_mode;
        length = `LEN_PTR_NO_OFS;
      end
      `MODE_PTR_BYTE_OFS, `MODE_PTR_BYTE_OFS_RMW: begin
        mode   = pointer_byte_offset_mode;
        length = `LEN_PTR_BYTE_OFS;
      end
      default: begin
        mode   = unsupported_mode;
        length = `LEN_PTR_NO_OFS;
      end
    endcase
  end
endmodule

// File: rtl/oag_defs.svh
// Constants for the operand address generator
`ifndef OAG_DEFS_SVH
`define OAG_DEFS_SVH
// Opcode upper nibble values selecting the operand mode
`define MODE_FULL_ADDR     4'hC
`define MODE_PTR_NO_OFS    4'hF
`define MODE_PTR_BYTE_OFS  4'hE
`define MODE_PTR_NO_OFS_RMW  4'h7
`define MODE_PTR_BYTE_OFS_RMW 4'h6
// Instruction lengths in bytes
`define LEN_FULL_ADDR      3'h3
`define LEN_PTR_NO_OFS     3'h1
`define LEN_PTR_BYTE_OFS   3'h2
// Reset values
`define ADDR_RESET         16'h0000
`define PC_RESET           16'h0000
`define BYTE_ZERO          8'h00
`define OP_RESET           4'h0
// Zero bits above the carry of a byte-offset address
`define CARRY_PAD          7'h00
`endif

// File: rtl/oag_pkg.sv
// Types shared by the operand address generator files
package oag_pkg;
  typedef enum logic [1:0] {
    full_address_mode,
    pointer_no_offset_mode,
    pointer_byte_offset_mode,
    unsupported_mode
  } operand_mode_e;
  typedef enum {
    st_idle,
    st_fetch1,
    st_fetch2
  } fetch_state_e;
endpackage

// File: rtl/operand_address_generator.sv
// Effective operand address generation for three addressing modes
//
// Function
// - Full-address mode: byte at PC+1 is high half, PC+2 low half.
// - Full-address instruction is three bytes, reaches all memory, PC advances three.
// - Pointer no-offset: low half is pointer, high half forced zero.
// - Pointer no-offset operands stay within the lowest 256 locations.
// - Pointer no-offset instruction is one byte; PC advances one.
// - Byte-offset mode adds pointer and next byte; PC advances two.
// - Byte-offset: low half is 8-bit sum, high half only the carry.
`timescale 1ns/10ps
`include "oag_defs.svh"
module operand_address_generator
  import oag_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [7:0]  code_byte,
  input  wire logic [7:0]  pointer,
  output logic             busy_q,
  output logic             done_q,
  output logic             bad_mode_q,
  output logic [7:0]       addr_high_q,
  output logic [7:0]       addr_low_q,
  output logic [3:0]       operation_q,
  output logic [1:0]       mode_q,
  output logic [15:0]      pc_q
);
  // ==========================================================
  // Constants
  // ==========================================================
  // Reset image of the address bus, split into its halves
  localparam logic [15:0] ADDR_INIT = `ADDR_RESET;
  localparam logic [7:0]  HIGH_INIT = ADDR_INIT[15:8];
  localparam logic [7:0]  LOW_INIT  = ADDR_INIT[7:0];
  // Operation field after reset
  localparam logic [3:0]  OP_INIT   = `OP_RESET;
  // Zero bits above the carry in a byte-offset address
  localparam logic [6:0]  CARRY_PAD = `CARRY_PAD;

  // A zero length would leave the program counter on the opcode
  if (`LEN_FULL_ADDR == 3'h0 || `LEN_PTR_NO_OFS == 3'h0 ||
      `LEN_PTR_BYTE_OFS == 3'h0) begin : g_len_check
    $error("instruction length of zero");
  end

  // ==========================================================
  // Decode
  // ==========================================================
  operand_mode_e dec_mode;
  logic [3:0]    dec_op;
  logic [2:0]    dec_len;
  mode_decode u_dec (
    .opcode    (code_byte),
    .mode      (dec_mode),
    .operation (dec_op),
    .length    (dec_len)
  );

  // ==========================================================
  // Sequencer
  // ==========================================================
  // Fetch progress and what the opcode asked for
  fetch_state_e  state_q, state_d;
  operand_mode_e cur_mode_q, cur_mode_d;
  logic [7:0]    first_q, first_d;
  logic          busy_d;
  logic          done_d;
  logic          bad_d;
  logic          accept;
  logic          finish_ofs;
  logic          finish_full;

  // Only an idle start is taken; starts during a fetch are dropped
  assign accept = start && (state_q == st_idle);

  // Byte-offset address completes on the first operand byte
  assign finish_ofs  = (state_q == st_fetch1) &&
                       (cur_mode_q == pointer_byte_offset_mode);
  // Full address completes on the second operand byte
  assign finish_full = (state_q == st_fetch2);

  // Opcode at PC, then PC+1 and PC+2 one a cycle; pointer held throughout
  always_comb begin
    state_d    = state_q;
    cur_mode_d = cur_mode_q;
    first_d    = first_q;
    busy_d     = busy_q;
    done_d     = 1'h0;
    bad_d      = bad_mode_q;
    case (state_q)
      st_idle: begin
        if (accept) begin
          cur_mode_d = dec_mode;
          bad_d      = 1'h0;
          case (dec_mode)
            pointer_no_offset_mode: begin
              done_d = 1'h1;
            end
            unsupported_mode: begin
              bad_d  = 1'h1; // Not ours: flag and skip one byte
              done_d = 1'h1;
            end
            default: begin
              busy_d  = 1'h1;
              state_d = st_fetch1;
            end
          endcase
        end
      end
      st_fetch1: begin
        if (finish_ofs) begin
          done_d  = 1'h1;
          busy_d  = 1'h0;
          state_d = st_idle;
        end else begin
          first_d = code_byte;
          state_d = st_fetch2;
        end
      end
      st_fetch2: begin
        done_d  = 1'h1;
        busy_d  = 1'h0;
        state_d = st_idle;
      end
      default: begin
        state_d = st_idle;
        busy_d  = 1'h0;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q    <= st_idle;
      cur_mode_q <= full_address_mode;
      first_q    <= `BYTE_ZERO;
      busy_q     <= 1'h0;
      done_q     <= 1'h0;
      bad_mode_q <= 1'h0;
    end else begin
      state_q    <= state_d;
      cur_mode_q <= cur_mode_d;
      first_q    <= first_d;
      busy_q     <= busy_d;
      done_q     <= done_d;
      bad_mode_q <= bad_d;
    end
  end

  // ==========================================================
  // Effective operand address
  // ==========================================================
  // Next address halves and the offset sum
  logic [7:0] hi_d;
  logic [7:0] lo_d;
  logic [8:0] ofs_sum;

  // Nine-bit sum keeps the carry for the high half
  assign ofs_sum = {1'h0, pointer} + {1'h0, code_byte};

  // Halves load together so the bus never shows a half update
  always_comb begin
    hi_d = addr_high_q;
    lo_d = addr_low_q;
    if (accept && dec_mode == pointer_no_offset_mode) begin
      hi_d = `BYTE_ZERO;
      lo_d = pointer;
    end else if (finish_ofs) begin
      hi_d = {CARRY_PAD, ofs_sum[8]};
      lo_d = ofs_sum[7:0];
    end else if (finish_full) begin
      hi_d = first_q;
      lo_d = code_byte;
    end
  end

  // Address registers; unsupported opcodes leave them alone
  always_ff @(posedge clock) begin
    if (rst) begin
      addr_high_q <= HIGH_INIT;
      addr_low_q  <= LOW_INIT;
    end else begin
      addr_high_q <= hi_d;
      addr_low_q  <= lo_d;
    end
  end

  // ==========================================================
  // Program counter and operation
  // ==========================================================
  // Next program counter and operation field
  logic [15:0] pc_d;
  logic [3:0]  op_d;

  // Advanced at acceptance, not at the end of the fetch
  always_comb begin
    pc_d = pc_q;
    op_d = operation_q;
    if (accept) begin
      pc_d = pc_q + 16'(dec_len);
      op_d = dec_op;
    end
  end

  // Program counter registers
  always_ff @(posedge clock) begin
    if (rst) begin
      pc_q        <= `PC_RESET;
      operation_q <= OP_INIT;
    end else begin
      pc_q        <= pc_d;
      operation_q <= op_d;
    end
  end

  // Mode of the last accepted opcode, for the execute stage
  assign mode_q = cur_mode_q;
endmodule

// File: verif/code_memory.sv
// Program memory model serving the opcode stream
`timescale 1ns/10ps
module code_memory (
  input  wire logic [15:0] addr,
  output logic      [7:0]  data
);
  logic [7:0] mem [0:65535];
  // Cleared so unwritten bytes never read unknown
  initial foreach (mem[i]) mem[i] = 8'h00;
  assign data = mem[addr];
endmodule

// File: verif/oag_properties.sv
// Port checker for the operand address generator
`timescale 1ns/10ps
module oag_properties (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        start,
  input wire logic        busy_q,
  input wire logic        done_q,
  input wire logic [7:0]  code_byte,
  input wire logic [7:0]  pointer,
  input wire logic [7:0]  addr_high_q,
  input wire logic [7:0]  addr_low_q,
  input wire logic [3:0]  operation_q,
  input wire logic [1:0]  mode_q,
  input wire logic [15:0] pc_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // ==========
  // Accepted start and the joined address halves
  wire        go = start && !busy_q;
  wire [15:0] ea = {addr_high_q, addr_low_q};
  a_full_hilo: assert property (done_q && mode_q == 2'h0 |->
    ea == {$past(code_byte, 2), $past(code_byte)}) else $error("full addr");
  a_full_len: assert property (go && code_byte[7:4] == 4'hC |=>
    pc_q == $past(pc_q) + 16'h3 ##2 done_q) else $error("full len");
  a_busy_pc: assert property (busy_q |=> $stable(pc_q)) else $error("pc moved");
  a_ptr_addr: assert property (done_q && mode_q == 2'h1 |->
    ea == {8'h00, $past(pointer)}) else $error("ptr addr");
  a_ptr_len: assert property (go && code_byte[7:4] == 4'hF |=>
    done_q && pc_q == $past(pc_q) + 16'h1) else $error("ptr len");
  a_ofs_len: assert property (go && code_byte[7:4] == 4'hE |=>
    !done_q && pc_q == $past(pc_q) + 16'h2 ##1 done_q) else $error("ofs len");
  a_ofs_sum: assert property (done_q && mode_q == 2'h2 |->
    ea == $past(pointer) + $past(code_byte)) else $error("ofs sum");
  a_op_nibble: assert property (go |=>
    operation_q == $past(code_byte[3:0])) else $error("operation");
  cover property (done_q && mode_q == 2'h0);
  cover property (done_q && mode_q == 2'h1);
  cover property (done_q && mode_q == 2'h2);
endmodule
bind operand_address_generator oag_properties oag_properties_i (.clock, .rst, .start,
  .busy_q, .done_q, .code_byte, .pointer, .addr_high_q, .addr_low_q, .operation_q,
  .mode_q, .pc_q);

// File: verif/tb_top.sv
// Bench for the operand address generator
`timescale 1ns/10ps
module tb_top;
  logic        clock = 1'h0, rst = 1'h1, start = 1'h0, busy_q, done_q, bad_mode_q;
  logic [7:0]  pointer = 8'h00, op, b1, b2, addr_high_q, addr_low_q;
  logic [15:0] fa = 16'h0000, ea_m = 16'h0000, pc_m = 16'h0000, pc_q;
  logic [3:0]  operation_q;
  logic [1:0]  mode_q, md;
  wire  [7:0]  code_byte;
  int          errors = 0, n_compared = 0, seed = 26, cyc = 0, k, len;
  always #2.5 clock = ~clock;
  code_memory code_memory_i (.addr(fa), .data(code_byte));
  operand_address_generator operand_address_generator_i (.clock, .rst, .start, .code_byte,
    .pointer, .busy_q, .done_q, .bad_mode_q, .addr_high_q, .addr_low_q, .operation_q,
    .mode_q, .pc_q);
  // Hang guard, far above 64 instructions
  always @(posedge clock) if (++cyc > 900) close_out(1);
  task automatic chk(input string nm, input logic [15:0] e, g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic close_out(input int hung);
    errors += hung;
    $display("compares %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ==========
  // Back-to-back random instructions, each against the model
  initial begin
    repeat (6) @(posedge clock);
    #1;
    rst = 1'h0;
    for (int i = 0; i < 64; i++) begin
      {op, b1, b2, pointer} = {i[3:0], 28'($random(seed))};
      // Two bits a nibble: C full, F/7 pointer, E/6 offset, rest unsupported
      md = 2'(32'h6CFF6FFF >> {op[7:4], 1'h0});
      len = md == 2'h0 ? 3 : md == 2'h2 ? 2 : 1;
      ea_m = md == 2'h0 ? {b1, b2} : md == 2'h1 ? 16'(pointer) : md == 2'h2 ? pointer + b1 : ea_m;
      code_memory_i.mem[pc_m] = op;
      code_memory_i.mem[pc_m + 16'h1] = b1;
      code_memory_i.mem[pc_m + 16'h2] = b2;
      fa = pc_m;
      start = 1'h1;
      for (k = 1; k <= len; k++) begin
        @(posedge clock);
        #1;
        if (k < len) begin
          chk("busy", 16'h0001, 16'(busy_q));
          start = k == 1; // Busy, so ignored
          fa++;
        end
      end
      pc_m += 16'(len);
      chk("idle", 16'h0000, 16'(busy_q));
      chk("done", 16'h0001, 16'(done_q));
      chk("pc", pc_m, pc_q);
      chk("address", ea_m, {addr_high_q, addr_low_q});
      chk("mode", {md == 2'h3, md, op[3:0]}, {bad_mode_q, mode_q, operation_q});
    end
    $display("instruction test done");
    close_out(0);
  end
endmodule
